// ### include/dtr_pkg.sv
// Constants and types shared by the dual channel torque removal block.
`default_nettype none
package dtr_pkg;
  // Clock rate and pulse tolerance of the safety inputs.
  localparam int unsigned ClkHz        = 40000000;
  localparam int unsigned PulseTolUs   = 1000;
  // Filter length: a pulse of up to the tolerance is ignored, so round up.
  localparam int unsigned FilterCycles =
    (PulseTolUs * (ClkHz / 1000000)) + 1;
  localparam int unsigned FiltW        = 16;

  // Indication selection field positions, two bits per drive state.
  localparam int unsigned SelRunLsb    = 0;
  localparam int unsigned SelStopLsb   = 2;
  // Indication codes: none, warning, event, fault (fault needs reset).
  localparam logic [1:0] IndNone       = 2'h0;
  localparam logic [1:0] IndWarn       = 2'h1;
  localparam logic [1:0] IndEvent      = 2'h2;
  localparam logic [1:0] IndFault      = 2'h3;

  // Drive run states, one-hot.
  typedef enum logic [2:0] {
    StIdle    = 3'h1,
    StRun     = 3'h2,
    StBlocked = 3'h4
  } dtr_state_t;
endpackage : dtr_pkg
`default_nettype wire

// ### sim/dtr_relay_model.sv
// Model of the external safety relay feeding both channels.
`timescale 1ns/10ps
`default_nettype none
module dtr_relay_model (
  input  wire logic core_clk,
  input  wire logic closeA,
  input  wire logic closeB,
  output logic      safetyInputA = 1'b0,
  output logic      safetyInputB = 1'b0
);
  // Both lines are always driven; contacts follow one cycle late.
  // Only one drive feeds the motor here, so opening this pair removes
  // all torque from it.
  always @(posedge core_clk) begin
    safetyInputA <= closeA;
    safetyInputB <= closeB;
  end
endmodule // dtr_relay_model
`default_nettype wire

// ### sim/dtr_torque_removal_sva.sv
// Port assertions for the torque removal block.
`timescale 1ns/10ps
`default_nettype none
module dtr_torque_removal_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic safetyInputA,
  input wire logic safetyInputB,
  input wire logic startCmd,
  input wire logic stopCmd,
  input wire logic faultReset,
  input wire logic gateDriveEn,
  input wire logic running,
  input wire logic channelALossFault,
  input wire logic channelBLossFault,
  input wire logic removalWarning,
  input wire logic removalFault
);
  // ------------------------------------------------------------
  // One clock domain, so clocking and reset are declared once.
  // ------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  gate_run_a: assert property (
    gateDriveEn |-> running && !removalWarning && !removalFault)
    else $error("gate on while removed");
  cut_first_a: assert property (
    $rose(removalFault || removalWarning) |-> !gateDriveEn
    && !$past(gateDriveEn)) else $error("indication before cut");
  fault_stop_a: assert property (
    (channelALossFault || channelBLossFault) |-> !running)
    else $error("run with fault");
  start_edge_a: assert property (
    $rose(running) |-> $past(startCmd, 2) && !$past(startCmd, 3))
    else $error("run without edge");
  both_on_a: assert property (
    $rose(running) |-> $past(safetyInputA, 3) && $past(safetyInputB, 3))
    else $error("run with pin off");
  stop_block_a: assert property (
    $rose(running) |-> !$past(stopCmd, 2))
    else $error("run under stop");
  a_fault_cause_a: assert property (
    $rose(channelALossFault) |-> !$past(safetyInputA, 10))
    else $error("a fault no loss");
  b_fault_cause_a: assert property (
    $rose(channelBLossFault) |-> !$past(safetyInputB, 10))
    else $error("b fault no loss");
  a_fault_hold_a: assert property (
    channelALossFault && !faultReset |=> channelALossFault)
    else $error("a fault dropped");
  b_fault_hold_a: assert property (
    channelBLossFault && !faultReset |=> channelBLossFault)
    else $error("b fault dropped");
endmodule // dtr_torque_removal_sva
`default_nettype wire

// ### sim/dtr_torque_removal_test.sv
// Self-checking bench for the torque removal block.
`timescale 1ns/10ps
`default_nettype none
module dtr_torque_removal_test;
  logic core_clk = 1'b0, rst = 1'b1, closeA = 1'b0, closeB = 1'b0;
  logic startCmd = 1'b0, stopCmd = 1'b0, faultReset = 1'b0;
  logic [3:0] indicationSel = 4'hc;
  logic safetyInputA, safetyInputB, gateDriveEn, running, removalEvent;
  logic channelALossFault, channelBLossFault, removalWarning, removalFault;
  int n_fail = 0, checks_done = 0, cycles = 0;
  // Rows: start, stop, expected run; held start must not restart.
  logic [2:0] rows [7] = '{3'h0, 3'h5, 3'h2, 3'h6, 3'h4, 3'h0, 3'h5};
  always #12.5 core_clk = ~core_clk;
  dtr_relay_model i_dtr_relay_model (.core_clk, .closeA, .closeB,
    .safetyInputA, .safetyInputB);
  dtr_torque_removal i_dtr_torque_removal (.core_clk, .rst, .safetyInputA,
    .safetyInputB, .startCmd, .stopCmd, .faultReset, .indicationSel,
    .gateDriveEn, .running, .channelALossFault, .channelBLossFault,
    .removalWarning, .removalEvent, .removalFault);
  task automatic check(string name, logic got, logic exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Two filter spans plus margin; a hang ends the run here.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      n_fail++;
      finish_test();
    end
  end
  // ------------------------------------------------------------
  // Main sequence, driven on falling edges.
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(negedge core_clk);
    check("gateDriveEn", gateDriveEn, 1'b0);
    check("removalFault", removalFault, 1'b0);
    rst = 1'b0;
    closeA = 1'b1;
    closeB = 1'b1;
    repeat (40010) @(negedge core_clk);
    foreach (rows[i]) begin
      {startCmd, stopCmd} = rows[i][2:1];
      repeat (4) @(negedge core_clk);
      check("running", running, rows[i][0]);
      check("gateDriveEn", gateDriveEn, rows[i][0]);
    end
    // A short dropout stays inside the pulse tolerance.
    closeA = 1'b0;
    repeat (4000) @(negedge core_clk);
    closeA = 1'b1;
    repeat (10) @(negedge core_clk);
    check("running", running, 1'b1);
    check("channelALossFault", channelALossFault, 1'b0);
    // Lose channel A only: warning for running, event for stopped, so a
    // wrong field choice shows up as an event.
    indicationSel = 4'h9;
    closeA = 1'b0;
    for (int i = 0; i < 40100 && gateDriveEn !== 1'b0; i++)
      @(negedge core_clk);
    repeat (3) @(negedge core_clk);
    check("gateDriveEn", gateDriveEn, 1'b0);
    check("channelALossFault", channelALossFault, 1'b1);
    check("channelBLossFault", channelBLossFault, 1'b0);
    check("removalWarning", removalWarning, 1'b1);
    check("removalFault", removalFault, 1'b0);
    check("removalEvent", removalEvent, 1'b0);
    startCmd = 1'b0;
    repeat (2) @(negedge core_clk);
    startCmd = 1'b1;
    faultReset = 1'b1;
    repeat (4) @(negedge core_clk);
    check("running", running, 1'b0);
    check("channelALossFault", channelALossFault, 1'b1);
    finish_test();
  end
endmodule // dtr_torque_removal_test
bind dtr_torque_removal dtr_torque_removal_sva i_dtr_torque_removal_sva (
  .core_clk, .rst, .safetyInputA, .safetyInputB, .startCmd, .stopCmd,
  .faultReset, .gateDriveEn, .running, .channelALossFault,
  .channelBLossFault, .removalWarning, .removalFault);
`default_nettype wire

// ### verilog/dtr_torque_removal.sv
// Dual channel torque removal: input filter, gate cut, faults, restart.
// Operation
// RULE_01 - Activation withdraws gate drive supply; a turning motor coasts.
// RULE_02 - External circuit must drive both channels; one channel is invalid.
// RULE_03 - External contacts change state within 200 ms of each other.
// RULE_04 - Pulses up to 1 ms on a channel are ignored.
// RULE_05 - Gate drive is cut first, indication follows afterwards.
// RULE_06 - Setting selects indications, separately for running and stopped.
// RULE_07 - Setting never affects gate drive removal.
// RULE_08 - Drive stops on channel loss; restart needs both channels, reset. Code needs a reset only while a channel or removal fault is latched.
// RULE_09 - Loss of only one channel always raises a fault.
// RULE_10 - No restart while either channel is de-energized.
// RULE_11 - After restore, reset if setting demands, and always new start.
// RULE_12 - Multiple drives on one motor must all be activated externally.
// RULE_13 - Single loss of channel a or b raises distinct faults.
// RULE_14 - Start requests are edge detected.
`timescale 1ns/10ps
`default_nettype none
module dtr_torque_removal (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       safetyInputA,
  input  wire logic       safetyInputB,
  input  wire logic       startCmd,
  input  wire logic       stopCmd,
  input  wire logic       faultReset,
  input  wire logic [3:0] indicationSel,
  output logic            gateDriveEn,
  output logic            running,
  output logic            channelALossFault,
  output logic            channelBLossFault,
  output logic            removalWarning,
  output logic            removalEvent,
  output logic            removalFault
);

  // ----------------------------------------------------------------
  // Input synchronisers and pulse filters
  // ----------------------------------------------------------------
  localparam int unsigned FiltW_L = dtr_pkg::FiltW;
  localparam logic [FiltW_L-1:0] FiltMax =
    FiltW_L'(dtr_pkg::FilterCycles);
  logic [1:0]         syncA_reg;
  logic [1:0]         syncB_reg;
  logic [FiltW_L-1:0] cntA_reg;
  logic [FiltW_L-1:0] cntB_reg;
  logic               chanA_reg;
  logic               chanB_reg;

  // Two flops per pin; only the second stage feeds the filters.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      syncA_reg <= 2'h0;
      syncB_reg <= 2'h0;
    end else begin
      syncA_reg <= {syncA_reg[0], safetyInputA};
      syncB_reg <= {syncB_reg[0], safetyInputB};
    end
  end

  // A channel changes state only after its pin holds the new level for
  // longer than the tolerance; shorter pulses such as test pulses from a
  // safety controller are absorbed. The cost is a fixed 1 ms reaction.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      chanA_reg <= 1'b0;
      chanB_reg <= 1'b0;
      cntA_reg  <= '0;
      cntB_reg  <= '0;
    end else begin
      if (syncA_reg[1] == chanA_reg) begin
        cntA_reg <= '0;
      end else if (cntA_reg == FiltMax) begin
        chanA_reg <= syncA_reg[1]; // RULE_04
        cntA_reg  <= '0;
      end else begin
        cntA_reg <= cntA_reg + 1'b1;
      end
      if (syncB_reg[1] == chanB_reg) begin
        cntB_reg <= '0;
      end else if (cntB_reg == FiltMax) begin
        chanB_reg <= syncB_reg[1]; // RULE_04
        cntB_reg  <= '0;
      end else begin
        cntB_reg <= cntB_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Drive state and gate drive
  // ----------------------------------------------------------------
  logic                 bothOn;
  logic                 startPrev_reg;
  logic                 startEdge;
  logic                 needReset_reg;
  logic                 anyFault;
  dtr_pkg::dtr_state_t  state_reg;

  assign bothOn    = chanA_reg & chanB_reg;
  assign startEdge = startCmd & ~startPrev_reg; // RULE_14
  assign anyFault  = channelALossFault | channelBLossFault | removalFault |
                     needReset_reg;

  // Remember the start level so a held command cannot restart by itself.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      startPrev_reg <= 1'b1;
    end else begin
      startPrev_reg <= startCmd;
    end
  end

  // Run sequencing; the indication setting reaches this logic only via removalFault and needReset_reg in anyFault, which block a start.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= dtr_pkg::StIdle;
    end else begin
      unique case (state_reg)
        dtr_pkg::StIdle: begin
          if (!bothOn) begin
            state_reg <= dtr_pkg::StBlocked; // RULE_10
          end else if (startEdge && !anyFault && !stopCmd) begin
            state_reg <= dtr_pkg::StRun; // RULE_11
          end
        end
        dtr_pkg::StRun: begin
          if (!bothOn) begin
            state_reg <= dtr_pkg::StBlocked; // RULE_08
          end else if (stopCmd) begin
            state_reg <= dtr_pkg::StIdle;
          end
        end
        dtr_pkg::StBlocked: begin
          if (bothOn) begin
            state_reg <= dtr_pkg::StIdle; // RULE_11
          end
        end
        default: state_reg <= dtr_pkg::StBlocked;
      endcase
    end
  end

  // Gate drive follows the channels directly, so it drops on the edge after
  // the filtered loss is seen, with the channel loss faults and ahead of warning, event and removal fault.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gateDriveEn <= 1'b0;
      running     <= 1'b0;
    end else begin
      gateDriveEn <= bothOn && (state_reg == dtr_pkg::StRun); // RULE_01 RULE_07
      running     <= bothOn && (state_reg == dtr_pkg::StRun); // RULE_08
    end
  end

  // ----------------------------------------------------------------
  // Indications and faults
  // ----------------------------------------------------------------
  logic       lossSeen;
  logic       wasRun;
  logic [1:0] sel;
  logic       lossPrev_reg;
  logic       lossPulse_reg;
  logic [1:0] selHeld_reg;

  assign lossSeen = ~bothOn & lossPrev_reg;
  assign wasRun   = (state_reg == dtr_pkg::StRun);
  assign sel      = wasRun ?
    indicationSel[dtr_pkg::SelRunLsb +: 2] :
    indicationSel[dtr_pkg::SelStopLsb +: 2]; // RULE_06

  // Edge of channel loss. The edge and the selection in force at that
  // moment are registered once more, so every indication appears one
  // edge after the gate cut and never ahead of it.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lossPrev_reg  <= 1'b0;
      lossPulse_reg <= 1'b0;
      selHeld_reg   <= dtr_pkg::IndNone;
    end else begin
      lossPrev_reg  <= bothOn;
      lossPulse_reg <= lossSeen; // RULE_05
      selHeld_reg   <= sel;
    end
  end

  // Sticky faults; a new loss wins over a simultaneous reset.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      channelALossFault <= 1'b0;
      channelBLossFault <= 1'b0;
      removalFault      <= 1'b0;
      needReset_reg     <= 1'b0;
    end else begin
      if (!chanA_reg && chanB_reg) begin
        channelALossFault <= 1'b1; // RULE_09 RULE_13
      end else if (faultReset) begin
        channelALossFault <= 1'b0;
      end
      if (chanA_reg && !chanB_reg) begin
        channelBLossFault <= 1'b1; // RULE_09 RULE_13
      end else if (faultReset) begin
        channelBLossFault <= 1'b0;
      end
      if (lossPulse_reg && selHeld_reg == dtr_pkg::IndFault) begin
        removalFault  <= 1'b1; // RULE_11
        needReset_reg <= 1'b1;
      end else if (faultReset && bothOn) begin
        removalFault  <= 1'b0;
        needReset_reg <= 1'b0;
      end
    end
  end

  // Warnings and events are levels held while the channels stay off.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      removalWarning <= 1'b0;
      removalEvent   <= 1'b0;
    end else begin
      if (lossPulse_reg) begin
        removalWarning <= (selHeld_reg == dtr_pkg::IndWarn); // RULE_06
        removalEvent   <= (selHeld_reg == dtr_pkg::IndEvent);
      end else if (bothOn) begin
        removalWarning <= 1'b0;
        removalEvent   <= 1'b0;
      end
    end
  end

endmodule // dtr_torque_removal
`default_nettype wire
